// file: ssd_gateway.sv
// Purpose: Behavioural gateway end of the serial diagnostic ring
// Assumes: One frame in flight at a time on an idle-high line
// Notes: Bits are launched and sampled on the falling clock edge
`timescale 1ns/1ps
module ssd_gateway (
   // Clock
   input wire logic clock,
   // Ring lines
   input wire logic from_chain,
   output logic to_chain
);
   initial to_chain = 1'b1;

   // Start bit, frame lsb first, stop bit leaves the line idle high
   task automatic send(input ssd_pkg::ssd_frame_t f);
      logic [ssd_pkg::TX_BITS-1:0] sh;
      sh = {1'b1, f, 1'b0};
      for (int i = 0; i < ssd_pkg::TX_BITS; i++) begin
         to_chain = sh[i];
         repeat (ssd_pkg::BIT_CYC) @(negedge clock);
      end
   endtask

   // Bounded wait for a start bit, then mid-bit sampling
   task automatic recv(output ssd_pkg::ssd_frame_t f, output logic ok);
      int n;
      n = 0;
      ok = 1'b0;
      f = '0;
      while (from_chain !== 1'b0 && n < 12000) begin
         @(negedge clock);
         n++;
      end
      if (n < 12000) begin
         repeat (ssd_pkg::HALF_CYC) @(negedge clock);
         for (int i = 0; i < ssd_pkg::FRAME_W; i++) begin
            repeat (ssd_pkg::BIT_CYC) @(negedge clock);
            f[i] = from_chain;
         end
         repeat (ssd_pkg::BIT_CYC) @(negedge clock);
         ok = (from_chain === 1'b1);
      end
   endtask
endmodule

// file: ssd_pkg.sv
// Purpose: Shared constants and types for the safety sensor serial diagnostic block
// Assumes: 200 MHz core clock, idle-high serial chain line, frames sent least significant bit first
// Notes: Byte layouts of request, response and warning-or-failure bytes are fixed here
//
// Functional notes
// - The chain holds up to 31 sensors and every frame carries a position count that addresses one of them.
// - Each sensor has a serial diagnostic input and output, and its safety inputs are the previous sensor's outputs.
// - Requests flow from the controller to the sensor, responses and warning-or-failure bytes flow back.
// - Losing the link never turns the safety outputs on or off by itself.
// - A failure-class fault turns the safety outputs off at once and sets the failure bit of the response.
// - A latched failure clears once its cause is gone and request bit 7 falls from one to zero, or the guard opens.
// - A failure at the safety outputs stays latched until the outputs are next released.
// - A warning other than a link error keeps the outputs on and sets the warning bit, and after 30 minutes becomes a failure; code drops warning bit 4.
// - A warning clears by itself once its cause has gone.
// - Every status and warning bit reads one exactly while its condition holds (code never reports warning bit 4); failure bits stay latched until cleared.
// - Response bits: 0 outputs on, 1 actuator seen, 4 both inputs, 5 limit range, 6 warning, 7 failure.
// - Fault bits: 0 and 1 output errors, 2 cross-wire, 3 overtemperature, 4 actuator fault, 5 internal.
// - Fault bit 6 flags a link error and bit 7 a low supply, both as warnings.
package ssd_pkg;
   localparam int CLK_NS = 5;
   localparam int BIT_TIME_NS = 1000;
   localparam int BIT_CYC = (BIT_TIME_NS + CLK_NS - 1) / CLK_NS;
   localparam int HALF_CYC = BIT_CYC / 2;
   localparam int TICK_NS = 1000000;
   localparam int TICK_CYC = TICK_NS / CLK_NS;
   localparam int WARN_DELAY_MIN = 30;
   localparam int WARN_TICKS = WARN_DELAY_MIN * 60 * (1000000000 / TICK_NS);
   localparam int COMM_TIMEOUT_MS = 100;
   localparam int COMM_TICKS = COMM_TIMEOUT_MS * 1000000 / TICK_NS;
   localparam int MAX_CHAIN = 31;
   localparam int HOP_W = 5;
   localparam int FRAME_W = 22;
   localparam int TX_BITS = FRAME_W + 2;
   localparam int REQ_RESET_BIT = 7;
   // Response byte
   localparam int RSP_ENABLED = 0;
   localparam int RSP_ACTUATOR = 1;
   localparam int RSP_INPUTS = 4;
   localparam int RSP_LIMIT = 5;
   localparam int RSP_WARNING = 6;
   localparam int RSP_FAILURE = 7;
   // Warning-or-failure byte
   localparam int WF_OUT_ONE = 0;
   localparam int WF_OUT_TWO = 1;
   localparam int WF_ACTUATOR = 4;
   localparam int WF_COMM = 6;
   localparam logic [7:0] WF_OUT_MASK = 8'h03;
   localparam logic [7:0] WF_FAIL_MASK = 8'h3f;
   localparam logic [7:0] WF_WARN_MASK = 8'hef;

   typedef struct packed {
      logic is_reply;
      logic [HOP_W-1:0] hops;
      logic [15:0] data;
   } ssd_frame_t;

   typedef struct packed {
      logic actuator;
      logic limit;
      logic in_one;
      logic in_two;
      logic [7:0] fail_cause;
      logic [7:0] warn_cause;
      logic diag_in;
   } ssd_pins_t;

   localparam ssd_pins_t PINS_RST = '{default: 1'b0, diag_in: 1'b1};
endpackage

// file: ssd_sensor.sv
// Purpose: Fault handling and serial diagnostic chain node of one safety sensor
// Assumes: All inputs are asynchronous pins; the gateway spaces frames by at least 25 bit times
// Notes: Frames are store-and-forward; a frame finishing while the transmitter is busy is dropped
`timescale 1ns/1ps
module ssd_sensor #(
   parameter int TICK_CYC = ssd_pkg::TICK_CYC,
   parameter int WARN_TICKS = ssd_pkg::WARN_TICKS
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Sensor pins
   input wire ssd_pkg::ssd_pins_t pins,
   // Safety and diagnostic outputs
   output logic safety_output_one,
   output logic safety_output_two,
   output logic diag_out
);
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ssd_rx_t;
   function automatic ssd_pkg::ssd_pins_t agree(input ssd_pkg::ssd_pins_t a, input ssd_pkg::ssd_pins_t b,
                                                  input ssd_pkg::ssd_pins_t held);
      agree = (a & ~(a ^ b)) | (held & (a ^ b));
   endfunction
   function automatic ssd_pkg::ssd_frame_t relay(input ssd_pkg::ssd_frame_t f);
      relay = f;
      relay.hops = f.is_reply ? f.hops + 5'h01 : f.hops - 5'h01;
   endfunction
   ssd_pkg::ssd_pins_t s1_reg, s2_reg, s3_reg, pf_reg;
   ssd_rx_t rx_state_reg;
   logic [7:0] rx_cnt_reg, tx_cnt_reg, fail_lat_reg, warn_bits;
   logic [7:0] controller_request_byte_reg, sensor_response_byte_reg, warning_failure_byte_reg;
   logic [4:0] rx_bits_reg, tx_bits_reg;
   logic [ssd_pkg::FRAME_W-1:0] rx_sh_reg;
   logic [ssd_pkg::TX_BITS-1:0] tx_sh_reg;
   logic [17:0] tick_cnt_reg;
   logic [15:0] comm_cnt_reg;
   logic [20:0] warn_cnt_reg;
   logic rx_valid_reg, tx_busy_reg, req_prev_reg, tick_reg, comm_err_reg, esc_reg, warn_prev_reg, rel_arm_reg;
   ssd_pkg::ssd_frame_t rx_frame, tx_frame;
   logic own_req, clear_evt, clr, warn_act, enable_next, enable_reg;
   // Three-stage synchroniser, value taken when stages two and three agree
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         s1_reg <= ssd_pkg::PINS_RST;
         s2_reg <= ssd_pkg::PINS_RST;
         s3_reg <= ssd_pkg::PINS_RST;
         pf_reg <= ssd_pkg::PINS_RST;
      end else begin
         s1_reg <= pins;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         pf_reg <= agree(s2_reg, s3_reg, pf_reg);
      end
   end

   // Serial receiver on the upstream diagnostic line
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rx_state_reg <= RX_IDLE;
         rx_cnt_reg <= 8'h00;
         rx_bits_reg <= 5'h00;
         rx_sh_reg <= '0;
         rx_valid_reg <= 1'b0;
      end else begin
         rx_valid_reg <= 1'b0;
         case (rx_state_reg)
            RX_IDLE: begin
               if (!pf_reg.diag_in) begin
                  rx_state_reg <= RX_START;
                  rx_cnt_reg <= 8'(ssd_pkg::HALF_CYC - 1);
               end
            end
            RX_START: begin
               if (rx_cnt_reg != 8'h00) begin
                  rx_cnt_reg <= rx_cnt_reg - 8'h01;
               end else if (!pf_reg.diag_in) begin
                  rx_state_reg <= RX_DATA;
                  rx_cnt_reg <= 8'(ssd_pkg::BIT_CYC - 1);
                  rx_bits_reg <= 5'h00;
               end else begin
                  rx_state_reg <= RX_IDLE;
               end
            end
            RX_DATA: begin
               if (rx_cnt_reg != 8'h00) begin
                  rx_cnt_reg <= rx_cnt_reg - 8'h01;
               end else begin
                  rx_sh_reg <= {pf_reg.diag_in, rx_sh_reg[ssd_pkg::FRAME_W-1:1]};
                  rx_cnt_reg <= 8'(ssd_pkg::BIT_CYC - 1);
                  rx_bits_reg <= rx_bits_reg + 5'h01;
                  if (rx_bits_reg == 5'(ssd_pkg::FRAME_W - 1)) begin
                     rx_state_reg <= RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               if (rx_cnt_reg != 8'h00) begin
                  rx_cnt_reg <= rx_cnt_reg - 8'h01;
               end else begin
                  rx_state_reg <= RX_IDLE;
                  rx_valid_reg <= pf_reg.diag_in;
               end
            end
            default: rx_state_reg <= RX_IDLE;
         endcase
      end
   end
   assign rx_frame = ssd_pkg::ssd_frame_t'(rx_sh_reg);
   assign own_req = rx_valid_reg && !rx_frame.is_reply && rx_frame.hops == 5'h00;
   // Own request answered with a reply, all other frames relayed down the chain
   always_comb begin
      if (own_req) begin
         tx_frame.is_reply = 1'b1;
         tx_frame.hops = 5'h00;
         tx_frame.data = {sensor_response_byte_reg, warning_failure_byte_reg};
      end else begin
         tx_frame = relay(rx_frame);
      end
   end

   // Serial transmitter on the downstream diagnostic line, idles high
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         tx_sh_reg <= '1;
         tx_busy_reg <= 1'b0;
         tx_cnt_reg <= 8'h00;
         tx_bits_reg <= 5'h00;
      end else if (!tx_busy_reg) begin
         if (rx_valid_reg) begin
            tx_sh_reg <= {1'b1, tx_frame, 1'b0};
            tx_busy_reg <= 1'b1;
            tx_cnt_reg <= 8'(ssd_pkg::BIT_CYC - 1);
            tx_bits_reg <= 5'h00;
         end
      end else if (tx_cnt_reg != 8'h00) begin
         tx_cnt_reg <= tx_cnt_reg - 8'h01;
      end else begin
         tx_sh_reg <= {1'b1, tx_sh_reg[ssd_pkg::TX_BITS-1:1]};
         tx_cnt_reg <= 8'(ssd_pkg::BIT_CYC - 1);
         tx_bits_reg <= tx_bits_reg + 5'h01;
         if (tx_bits_reg == 5'(ssd_pkg::TX_BITS - 1)) begin
            tx_busy_reg <= 1'b0;
         end
      end
   end
   assign diag_out = tx_sh_reg[0];
   // Request byte and its reset-bit history
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         controller_request_byte_reg <= 8'h00;
         req_prev_reg <= 1'b0;
      end else begin
         if (own_req) begin
            controller_request_byte_reg <= rx_frame.data[7:0];
         end
         req_prev_reg <= controller_request_byte_reg[ssd_pkg::REQ_RESET_BIT];
      end
   end
   assign clear_evt = req_prev_reg && !controller_request_byte_reg[ssd_pkg::REQ_RESET_BIT];
   assign clr = clear_evt || !pf_reg.actuator;
   // Prescaled tick and link watchdog
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         tick_cnt_reg <= 18'h00000;
         tick_reg <= 1'b0;
         comm_cnt_reg <= 16'h0000;
         comm_err_reg <= 1'b0;
      end else begin
         tick_reg <= tick_cnt_reg == 18'(TICK_CYC - 1);
         tick_cnt_reg <= (tick_cnt_reg == 18'(TICK_CYC - 1)) ? 18'h00000 : tick_cnt_reg + 18'h00001;
         if (own_req) begin
            comm_cnt_reg <= 16'h0000;
            comm_err_reg <= 1'b0;
         end else if (tick_reg && !comm_err_reg) begin
            comm_cnt_reg <= comm_cnt_reg + 16'h0001;
            comm_err_reg <= comm_cnt_reg == 16'(ssd_pkg::COMM_TICKS - 1);
         end
      end
   end
   // Link error is reported only; it does not enter escalation or output control
   assign warn_act = |(pf_reg.warn_cause & ssd_pkg::WF_WARN_MASK & ~(8'h01 << ssd_pkg::WF_COMM));
   // Warning escalation timer
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         warn_cnt_reg <= 21'h000000;
         warn_prev_reg <= 1'b0;
         esc_reg <= 1'b0;
      end else begin
         warn_prev_reg <= warn_act;
         if (!warn_act || !warn_prev_reg) begin
            warn_cnt_reg <= 21'h000000;
         end else if (tick_reg && warn_cnt_reg != 21'(WARN_TICKS - 1)) begin
            warn_cnt_reg <= warn_cnt_reg + 21'h000001;
         end
         if (warn_act && tick_reg && warn_cnt_reg == 21'(WARN_TICKS - 1)) begin
            esc_reg <= 1'b1;
         end else if (!warn_act && clr) begin
            esc_reg <= 1'b0;
         end
      end
   end

   // Failure latch; output faults wait for the next release
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         fail_lat_reg <= 8'h00;
         rel_arm_reg <= 1'b0;
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (pf_reg.fail_cause[i] && ssd_pkg::WF_FAIL_MASK[i]) begin
               fail_lat_reg[i] <= 1'b1;
            end else if (ssd_pkg::WF_OUT_MASK[i]) begin
               if (enable_next && !enable_reg) begin
                  fail_lat_reg[i] <= 1'b0;
               end
            end else if (clr) begin
               fail_lat_reg[i] <= 1'b0;
            end
         end
         if (clr && |(fail_lat_reg & ssd_pkg::WF_OUT_MASK)) begin
            rel_arm_reg <= 1'b1;
         end else if (enable_next) begin
            rel_arm_reg <= 1'b0;
         end
      end
   end

   always_comb begin
      enable_next = pf_reg.actuator && pf_reg.in_one && pf_reg.in_two && !esc_reg;
      if (|(fail_lat_reg & ~ssd_pkg::WF_OUT_MASK) || |(pf_reg.fail_cause & ssd_pkg::WF_FAIL_MASK)) begin
         enable_next = 1'b0;
      end
      if (|(fail_lat_reg & ssd_pkg::WF_OUT_MASK) && !rel_arm_reg) begin
         enable_next = 1'b0;
      end
   end

   assign warn_bits = (pf_reg.warn_cause & ssd_pkg::WF_WARN_MASK & ~(8'h01 << ssd_pkg::WF_COMM))
                      | (8'(comm_err_reg) << ssd_pkg::WF_COMM);

   // Safety outputs and the two status bytes
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         enable_reg <= 1'b0;
         sensor_response_byte_reg <= 8'h00;
         warning_failure_byte_reg <= 8'h00;
      end else begin
         enable_reg <= enable_next;
         sensor_response_byte_reg <= 8'h00;
         sensor_response_byte_reg[ssd_pkg::RSP_ENABLED] <= enable_reg;
         sensor_response_byte_reg[ssd_pkg::RSP_ACTUATOR] <= pf_reg.actuator;
         sensor_response_byte_reg[ssd_pkg::RSP_INPUTS] <= pf_reg.in_one && pf_reg.in_two;
         sensor_response_byte_reg[ssd_pkg::RSP_LIMIT] <= pf_reg.limit;
         sensor_response_byte_reg[ssd_pkg::RSP_WARNING] <= warn_act;
         sensor_response_byte_reg[ssd_pkg::RSP_FAILURE] <= |fail_lat_reg || esc_reg;
         warning_failure_byte_reg <= fail_lat_reg | warn_bits;
      end
   end

   assign safety_output_one = enable_reg;
   assign safety_output_two = enable_reg;

   sequence s_fault_seen;
      |(pf_reg.fail_cause & ssd_pkg::WF_FAIL_MASK);
   endsequence
   sequence s_reset_step;
      controller_request_byte_reg[ssd_pkg::REQ_RESET_BIT] ##1 !controller_request_byte_reg[ssd_pkg::REQ_RESET_BIT];
   endsequence
   chk_fail_off_now: assert property (@(posedge clock) disable iff (!reset_n)
      s_fault_seen |=> !safety_output_one ##1 sensor_response_byte_reg[ssd_pkg::RSP_FAILURE])
      else $error("Outputs not off after failure");
   chk_reset_step_once: assert property (@(posedge clock) disable iff (!reset_n)
      s_reset_step |-> clear_evt ##1 !clear_evt) else $error("Reset step not a single event");
   chk_fail_clears: assert property (@(posedge clock) disable iff (!reset_n)
      clear_evt && !(|pf_reg.fail_cause) |=> (fail_lat_reg & ~ssd_pkg::WF_OUT_MASK) == 8'h00)
      else $error("Failure not cleared by reset step");
   chk_out_fault_held: assert property (@(posedge clock) disable iff (!reset_n)
      fail_lat_reg[ssd_pkg::WF_OUT_ONE] && !enable_next |=> fail_lat_reg[ssd_pkg::WF_OUT_ONE])
      else $error("Output fault dropped before release");
   chk_escalate_off: assert property (@(posedge clock) disable iff (!reset_n)
      warn_act && tick_reg && warn_cnt_reg == 21'(WARN_TICKS - 1) |=> esc_reg ##1 !enable_reg)
      else $error("Warning did not escalate");
   chk_warn_restart: assert property (@(posedge clock) disable iff (!reset_n)
      !warn_act |=> warn_cnt_reg == 21'h000000 && !sensor_response_byte_reg[ssd_pkg::RSP_WARNING])
      else $error("Warning timer or flag not cleared");
   chk_comm_flag: assert property (@(posedge clock) disable iff (!reset_n)
      comm_err_reg |=> warning_failure_byte_reg[ssd_pkg::WF_COMM]) else $error("Link error not flagged");
   chk_comm_hold: assert property (@(posedge clock) disable iff (!reset_n)
      $rose(comm_err_reg) && $stable(pf_reg) && $stable(fail_lat_reg) && $stable(esc_reg) && $stable(rel_arm_reg)
      |=> $stable(enable_reg))
      else $error("Link loss changed outputs");
   chk_own_reply: assert property (@(posedge clock) disable iff (!reset_n)
      own_req && !tx_busy_reg |=> tx_busy_reg && !diag_out && tx_sh_reg[ssd_pkg::FRAME_W])
      else $error("No reply started for own request");
   chk_rsp_layout: assert property (@(posedge clock) disable iff (!reset_n)
      ##1 sensor_response_byte_reg[3:2] == 2'b00 && sensor_response_byte_reg[0] == $past(enable_reg))
      else $error("Response byte layout wrong");
endmodule

// file: tb.sv
// Purpose: Self-checking bench for one sensor node closed in a ring with the gateway model
// Assumes: Shortened tick and escalation counts
// Notes: Inputs change on the falling clock edge
`timescale 1ns/1ps
module tb;
   localparam int TICK = 200;
   localparam int WARN = 50;
   logic clock, reset_n, act, lim, in1, in2, gw_line, out_one, out_two, diag_out;
   logic [7:0] fail, warn;
   ssd_pkg::ssd_pins_t pins;
   int n_fail = 0;
   int tests_run = 0;
   int cyc = 0;

   assign pins = {act, lim, in1, in2, fail, warn, gw_line};

   ssd_sensor #(.TICK_CYC(TICK), .WARN_TICKS(WARN)) DUT (
      .clock(clock), .reset_n(reset_n), .pins(pins),
      .safety_output_one(out_one), .safety_output_two(out_two), .diag_out(diag_out));
   ssd_gateway gw (.clock(clock), .from_chain(diag_out), .to_chain(gw_line));

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   always @(posedge clock) cyc <= cyc + 1;

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task final_report;
      if (n_fail == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic exchange(input logic [4:0] hops, input logic [7:0] req, output ssd_pkg::ssd_frame_t rx);
      ssd_pkg::ssd_frame_t tx;
      logic ok;
      tx = '{is_reply: 1'b0, hops: hops, data: {8'h00, req}};
      fork
         gw.send(tx);
         gw.recv(rx, ok);
      join
      chk({15'h0000, ok}, 16'h0001);
      repeat (20) @(negedge clock);
   endtask

   task automatic wait_out(input logic v, input int lim_cyc);
      int n;
      n = 0;
      while (out_one !== v && n < lim_cyc) begin
         @(negedge clock);
         n++;
      end
   endtask

   task automatic t_reset;
      reset_n = 1'b0;
      repeat (20) @(negedge clock);
      chk({13'h0000, out_one, out_two, diag_out}, 16'h0001);
      reset_n = 1'b1;
      repeat (5) @(negedge clock);
   endtask

   task automatic t_relay;
      ssd_pkg::ssd_frame_t rx;
      exchange(5'd3, 8'ha5, rx);
      chk({10'h000, rx.is_reply, rx.hops}, 16'h0002);
      chk(rx.data, 16'h00a5);
   endtask

   task automatic t_normal;
      ssd_pkg::ssd_frame_t rx;
      act = 1'b1;
      in1 = 1'b1;
      in2 = 1'b1;
      wait_out(1'b1, 40);
      chk({14'h0000, out_one, out_two}, 16'h0003);
      exchange(5'd0, 8'h00, rx);
      chk({10'h000, rx.is_reply, rx.hops}, 16'h0020);
      chk(rx.data, 16'h1300);
   endtask

   task automatic t_warning;
      ssd_pkg::ssd_frame_t rx;
      int t0;
      int el;
      lim = 1'b1;
      warn = 8'h08;
      t0 = cyc;
      exchange(5'd0, 8'h00, rx);
      chk(rx.data, 16'h7308);
      chk({15'h0000, out_one}, 16'h0001);
      wait_out(1'b0, 3000);
      el = cyc - t0;
      chk({15'h0000, el >= (WARN - 1) * TICK && el <= (WARN + 1) * TICK + 20}, 16'h0001);
      chk({14'h0000, out_one, out_two}, 16'h0000);
   endtask

   task automatic t_guard;
      warn = 8'h00;
      repeat (10) @(negedge clock);
      act = 1'b0;
      repeat (10) @(negedge clock);
      act = 1'b1;
      wait_out(1'b1, 40);
      chk({14'h0000, out_one, out_two}, 16'h0003);
   endtask

   task automatic t_failure;
      ssd_pkg::ssd_frame_t rx;
      fail = 8'h05;
      repeat (8) @(negedge clock);
      chk({14'h0000, out_one, out_two}, 16'h0000);
      exchange(5'd0, 8'h00, rx);
      chk(rx.data, 16'hb205);
      fail = 8'h00;
      exchange(5'd0, 8'h80, rx);
      chk(rx.data, 16'hb205);
      exchange(5'd0, 8'h00, rx);
      wait_out(1'b1, 40);
      chk({14'h0000, out_one, out_two}, 16'h0003);
      exchange(5'd0, 8'h00, rx);
      chk(rx.data, 16'h3300);
   endtask

   task automatic t_link;
      ssd_pkg::ssd_frame_t rx;
      repeat (17000) @(negedge clock);
      chk({14'h0000, out_one, out_two}, 16'h0003);
      exchange(5'd0, 8'h00, rx);
      chk(rx.data, 16'h3340);
   endtask

   initial begin
      repeat (98000) @(posedge clock);
      n_fail++;
      final_report;
   end

   initial begin
      reset_n = 1'b0;
      act = 1'b0;
      lim = 1'b0;
      in1 = 1'b0;
      in2 = 1'b0;
      fail = 8'h00;
      warn = 8'h00;
      @(negedge clock);
      t_reset;
      t_relay;
      t_normal;
      t_warning;
      t_guard;
      t_failure;
      t_link;
      final_report;
   end
endmodule
